// >>> common/iit_pkg.sv
// package: register map, field layout and constants of the idle interval timer
package iit_pkg;
   // ------------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [11:0] MODE_OFF    = 12'h000;
   localparam logic [11:0] IRQCTL_OFF  = 12'h004;
   localparam logic [11:0] STATUS_OFF  = 12'h008;
   localparam logic [11:0] CLEAR_OFF   = 12'h00c;
   localparam logic [11:0] ENABLE_OFF  = 12'h010;
   localparam logic [11:0] CTRL_OFF    = 12'h014;
   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int SEL_LSB      = 0;
   localparam int RSVD_BIT     = 3;
   localparam int LOW_SPEED_OSC_ON_BIT     = 7;
   localparam int HIGH_SPEED_OSC_ON_BIT     = 6;
   localparam int DUAL_CLOCK_ENABLE_BIT     = 5;
   localparam int CKSEL_BIT    = 4;
   localparam int PEND_BIT     = 5;
   localparam int TEN_BIT      = 4;
   localparam int GIE_BIT      = 0;
   localparam int PORTG_BIT    = 6;
   localparam int TICK_LOW_BIT = 11;
   // ------------------------------------------------------------------
   // reset values and counts
   // ------------------------------------------------------------------
   localparam logic [7:0]  MODE_RST    = 8'h40;
   localparam logic [7:0]  IRQCTL_RST  = 8'h00;
   localparam logic [15:0] CNT_RST     = 16'hffff;
   localparam logic [2:0]  SEL_MAX     = 3'h4;
   localparam logic [3:0]  IRQ_EV_RST  = 4'h0;
   localparam int          HS_DIV      = 5;
   localparam int          LS_DIV      = 8;
   localparam logic [2:0]  HS_DIV_LAST = 3'(HS_DIV - 1);
   localparam logic [2:0]  LS_DIV_LAST = 3'(LS_DIV - 1);
   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic       low_speed_osc_on;
      logic       high_speed_osc_on;
      logic       dual_clock_enable;
      logic       cksel;
      logic       rsvd;
      logic [2:0] sel;
   } iit_mode_t;

   typedef struct packed {
      logic        tick;
      logic        wake;
      logic        wdog_tick;
      logic        force_reset;
   } iit_evt_t;
endpackage : iit_pkg

// >>> src/iit_clk_sel.sv
// clock selection: counter enable from instruction clock or slow clock
`timescale 1ns/1ps
`default_nettype none
module iit_clk_sel (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic slow_mode,
   input  wire logic slow_clk_tick,
   output logic      cnt_step,
   output logic      div_active
);
   logic [2:0] div_reg;
   logic [2:0] div_next;
   logic       step_next;

   // ------------------------------------------------------------------
   // divider
   // ------------------------------------------------------------------
   always_comb begin
      div_next  = div_reg;
      step_next = 1'b0;
      if (slow_mode) begin
         div_next  = 3'h0;
         step_next = slow_clk_tick;
      end else if (div_reg == iit_pkg::HS_DIV_LAST) begin
         div_next  = 3'h0;
         step_next = 1'b1;
      end else begin
         div_next = div_reg + 3'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg    <= 3'h0;
         cnt_step   <= 1'b0;
         div_active <= 1'b0;
      end else begin
         div_reg    <= div_next;
         cnt_step   <= step_next;
         div_active <= !slow_mode;
      end
   end
endmodule : iit_clk_sel
`default_nettype wire

// >>> src/iit_counter.sv
// free-running 16-bit down counter with selectable tick bit
`timescale 1ns/1ps
`default_nettype none
module iit_counter (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       step,
   input  wire logic [2:0] sel,
   output logic            tick,
   output logic            wdog_tick
);
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic        tick_next;
   logic        wd_next;

   function automatic logic bit_falls(input logic [15:0] c, input logic [2:0] s);
      int b;
      b = iit_pkg::TICK_LOW_BIT + int'(s);
      bit_falls = (c[b -: 1] == 1'b0) && ((c & ((16'h1 << b) - 16'h1)) == 16'h0);
   endfunction : bit_falls

   // ------------------------------------------------------------------
   // count
   // ------------------------------------------------------------------
   always_comb begin
      cnt_next  = cnt_reg;
      tick_next = 1'b0;
      wd_next   = 1'b0;
      if (step) begin
         cnt_next = cnt_reg - 16'h1;
         if (sel <= iit_pkg::SEL_MAX)
            tick_next = bit_falls(cnt_reg, sel);
         wd_next = bit_falls(cnt_reg, 3'h4);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg   <= iit_pkg::CNT_RST;
         tick      <= 1'b0;
         wdog_tick <= 1'b0;
      end else begin
         cnt_reg   <= cnt_next;
         tick      <= tick_next;
         wdog_tick <= wd_next;
      end
   end
endmodule : iit_counter
`default_nettype wire

// >>> src/iit_top.sv
// idle interval timer: apb registers, tick flag, wake and interrupt
`timescale 1ns/1ps
`default_nettype none
// Operation
// - 16-bit down counter, invisible to software
// - fast mode: count instruction clock
// - slow modes: count 32 kHz clock
// - slow modes: instruction divider stopped
// - counter times wake, watchdog, start delays
// - selected bit 11-15 underflow sets pending
// - tick clears port G bit six
// - idle_irq_req needs tick enable and global enable
// - pending bit 5, enable bit 4
// - period select in mode bits 0-2
// - codes 0-4 give 4k..64k clocks
// - reset clears period select
// - zeros in upper mode bits force reset
// - select change may set pending spuriously
module iit_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        slow_clk_tick,
   output logic             irq,
   output logic             idle_irq_req,
   output logic             port_g_wake_n,
   output logic             wdog_tick_out,
   output logic             start_delay_done,
   output logic             clock_reset_req,
   output logic             instr_div_on
);
   iit_pkg::iit_mode_t mode_reg;
   iit_pkg::iit_mode_t mode_next;
   logic [7:0]         irqctl_reg;
   logic [7:0]         irqctl_next;
   logic [3:0]         sts_reg;
   logic [3:0]         sts_next;
   logic [3:0]         en_reg;
   logic [3:0]         en_next;
   logic               ctrl_reg;
   logic               ctrl_next;
   logic [31:0]        rd_next;
   logic               err_next;
   logic               irq_next;
   logic               req_next;
   logic               wake_n_next;
   logic               rst_next;
   logic               sdd_next;
   logic               sdd_reg;
   iit_pkg::iit_evt_t  ev;
   logic               step;
   logic               div_on;
   logic               slow_mode;
   logic               wr;
   logic               rd;
   logic               setup;

   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == iit_pkg::MODE_OFF) || (a == iit_pkg::IRQCTL_OFF) || (a == iit_pkg::STATUS_OFF)
               || (a == iit_pkg::CLEAR_OFF) || (a == iit_pkg::ENABLE_OFF) || (a == iit_pkg::CTRL_OFF);
   endfunction : mapped

   // read data and error launched from setup, so they stand in the access cycle
   assign wr        = psel && penable && pwrite;
   assign rd        = psel && !penable && !pwrite;
   assign setup     = psel && !penable;
   assign slow_mode = mode_reg.dual_clock_enable || mode_reg.cksel;

   // ------------------------------------------------------------------
   // submodules
   // ------------------------------------------------------------------
   iit_clk_sel u_clk (
      .pclk          (pclk),
      .presetn       (presetn),
      .slow_mode     (slow_mode),
      .slow_clk_tick (slow_clk_tick),
      .cnt_step      (step),
      .div_active    (div_on)
   );

   iit_counter u_cnt (
      .pclk      (pclk),
      .presetn   (presetn),
      .step      (step),
      .sel       (mode_reg.sel),
      .tick      (ev.tick),
      .wdog_tick (ev.wdog_tick)
   );

   assign ev.wake        = ev.tick;
   assign ev.force_reset = wr && (paddr == iit_pkg::MODE_OFF) && (pwdata[7:4] == 4'h0);

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   always_comb begin
      mode_next   = mode_reg;
      irqctl_next = irqctl_reg;
      en_next     = en_reg;
      ctrl_next   = ctrl_reg;
      sts_next    = sts_reg;
      err_next    = 1'b0;
      rd_next     = 32'h0;
      if (wr) begin
         case (paddr)
            iit_pkg::MODE_OFF: begin
               if (pwdata[7:4] != 4'h0)
                  mode_next = iit_pkg::iit_mode_t'({pwdata[7:4], 1'b0, pwdata[2:0]});
            end
            iit_pkg::IRQCTL_OFF: irqctl_next = pwdata[7:0];
            iit_pkg::CLEAR_OFF:  sts_next    = sts_reg & ~pwdata[3:0];
            iit_pkg::ENABLE_OFF: en_next     = pwdata[3:0];
            iit_pkg::CTRL_OFF:   ctrl_next   = pwdata[iit_pkg::GIE_BIT];
            default:             sts_next    = sts_reg;
         endcase
      end
      if (rd) begin
         case (paddr)
            iit_pkg::MODE_OFF:   rd_next = {24'h0, mode_reg};
            iit_pkg::IRQCTL_OFF: rd_next = {24'h0, irqctl_reg};
            iit_pkg::STATUS_OFF: rd_next = {28'h0, sts_reg};
            iit_pkg::ENABLE_OFF: rd_next = {28'h0, en_reg};
            iit_pkg::CTRL_OFF:   rd_next = {31'h0, ctrl_reg};
            iit_pkg::CLEAR_OFF:  rd_next = 32'h0;
            default:             rd_next = 32'h0;
         endcase
      end
      err_next = setup && !mapped(paddr);
      if (ev.tick)
         irqctl_next[iit_pkg::PEND_BIT] = 1'b1;
      sts_next = sts_next | ev;
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   always_comb begin
      irq_next    = |(sts_reg & en_reg);
      req_next    = irqctl_reg[iit_pkg::PEND_BIT] && irqctl_reg[iit_pkg::TEN_BIT] && ctrl_reg;
      wake_n_next = !ev.wake;
      rst_next    = ev.force_reset;
      sdd_next    = sdd_reg || ev.wdog_tick;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg         <= iit_pkg::iit_mode_t'(iit_pkg::MODE_RST);
         irqctl_reg       <= iit_pkg::IRQCTL_RST;
         sts_reg          <= iit_pkg::IRQ_EV_RST;
         en_reg           <= iit_pkg::IRQ_EV_RST;
         ctrl_reg         <= 1'b0;
         sdd_reg          <= 1'b0;
         prdata           <= 32'h0;
         pready           <= 1'b0;
         pslverr          <= 1'b0;
         irq              <= 1'b0;
         idle_irq_req     <= 1'b0;
         port_g_wake_n    <= 1'b1;
         wdog_tick_out    <= 1'b0;
         start_delay_done <= 1'b0;
         clock_reset_req  <= 1'b0;
         instr_div_on     <= 1'b0;
      end else begin
         mode_reg         <= mode_next;
         irqctl_reg       <= irqctl_next;
         sts_reg          <= sts_next;
         en_reg           <= en_next;
         ctrl_reg         <= ctrl_next;
         sdd_reg          <= sdd_next;
         prdata           <= rd_next;
         pready           <= psel && !penable;
         pslverr          <= err_next;
         irq              <= irq_next;
         idle_irq_req     <= req_next;
         port_g_wake_n    <= wake_n_next;
         wdog_tick_out    <= ev.wdog_tick;
         start_delay_done <= sdd_next;
         clock_reset_req  <= rst_next;
         instr_div_on     <= div_on;
      end
   end
endmodule : iit_top
`default_nettype wire

// >>> tb/iit_checker.sv
// checker: port assertions of the idle interval timer
`timescale 1ns/1ps
`default_nettype none
module iit_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        irq,
   input wire logic        idle_irq_req,
   input wire logic        port_g_wake_n,
   input wire logic        clock_reset_req,
   input wire logic        instr_div_on
);
   logic wr;
   logic mw;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign wr = psel & penable & pwrite;
   assign mw = wr & pready & (paddr == iit_pkg::MODE_OFF);
   AST_WAKE_ONE: assert property (!port_g_wake_n |=> port_g_wake_n)
      else $error("wake pulse too long");
   AST_WAKE_GAP: assert property ($fell(port_g_wake_n) |=> port_g_wake_n [*4])
      else $error("ticks too close");
   AST_CLK_RST: assert property (mw && pwdata[7:4] == 4'h0 |=> clock_reset_req)
      else $error("no reset request");
   AST_CLK_RST_ONE: assert property (clock_reset_req |=> !clock_reset_req)
      else $error("reset request too long");
   AST_SLOW_DIV: assert property (mw && pwdata[5:4] != 2'h0 |-> ##[1:3] !instr_div_on)
      else $error("divider still on");
   AST_FAST_DIV: assert property (mw && pwdata[7:6] != 2'h0 && pwdata[5:4] == 2'h0 |-> ##[1:3] instr_div_on)
      else $error("divider off");
   AST_PEND_HOLD: assert property ($fell(idle_irq_req) |-> $past(wr) || $past(wr, 2) || $past(wr, 3))
      else $error("request dropped without write");
   AST_IRQ_HOLD: assert property ($fell(irq) |-> $past(wr) || $past(wr, 2) || $past(wr, 3))
      else $error("irq dropped without write");
   CV_WAKE: cover property ($fell(port_g_wake_n));
   CV_RST: cover property (clock_reset_req);
   CV_IRQ: cover property ($rose(idle_irq_req));
endmodule : iit_checker
bind iit_top iit_checker u_iit_checker (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .irq(irq), .idle_irq_req(idle_irq_req),
   .port_g_wake_n(port_g_wake_n), .clock_reset_req(clock_reset_req), .instr_div_on(instr_div_on));
`default_nettype wire

// >>> tb/iit_tb_top.sv
// testbench: apb traffic, tick timing and interrupts of the idle interval timer
`timescale 1ns/1ps
`default_nettype none
module iit_tb_top;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slow_clk_tick;
   logic        irq, idle_irq_req, port_g_wake_n, wdog_tick_out, start_delay_done;
   logic        clock_reset_req, instr_div_on;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, lfsr_v;
   logic [32:0] exp_q[$];
   int          err_total, tests_run, n;

   iit_top u_iit_top (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .slow_clk_tick(slow_clk_tick), .irq(irq), .idle_irq_req(idle_irq_req),
      .port_g_wake_n(port_g_wake_n), .wdog_tick_out(wdog_tick_out), .start_delay_done(start_delay_done),
      .clock_reset_req(clock_reset_req), .instr_div_on(instr_div_on)
   );

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // slow clock pulse every other cycle, ignored in fast mode
   always @(posedge pclk) slow_clk_tick <= presetn ? ~slow_clk_tick : 1'b0;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : results

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
      int k;
      if (!w)
         exp_q.push_back(e);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(negedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      @(posedge pclk);
      psel    <= 1'b0;
      penable <= 1'b0;
      if (k >= 50) begin
         err_total++;
         results();
      end
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      apb(1'b0, a, 32'h0, e);
   endtask : rd

   // cycles up to the next wake pulse
   task automatic gap(output int c);
      c = 0;
      do begin
         @(negedge pclk);
         c++;
      end while (port_g_wake_n !== 1'b0 && c < 70000);
      if (c >= 70000) begin
         err_total++;
         results();
      end
   endtask : gap

   // read result monitor
   always @(negedge pclk) begin
      if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0)
         chk({pslverr, prdata}, exp_q.pop_front());
   end

   initial begin
      {presetn, psel, penable, pwrite} = 4'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      err_total = 0;
      tests_run = 0;
      lfsr_v = 32'h0000_7fe4;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(iit_pkg::MODE_OFF, 33'h40);
      rd(12'hffc, 33'h1_0000_0000);
      wr(iit_pkg::MODE_OFF, 32'h07);
      rd(iit_pkg::MODE_OFF, 33'h40);
      wr(iit_pkg::MODE_OFF, 32'h47);
      rd(iit_pkg::MODE_OFF, 33'h47);
      wr(iit_pkg::MODE_OFF, 32'h40);
      for (int i = 0; i < 4; i++) begin
         lfsr_v = lfsr(lfsr_v);
         wr(iit_pkg::ENABLE_OFF, lfsr_v);
         rd(iit_pkg::ENABLE_OFF, {29'h0, lfsr_v[3:0]});
      end
      wr(iit_pkg::ENABLE_OFF, 32'h8);
      wr(iit_pkg::CTRL_OFF, 32'h1);
      wr(iit_pkg::IRQCTL_OFF, 32'h10);
      chk({32'h0, instr_div_on}, 33'h1);
      gap(n);
      gap(n);
      chk(33'(n), 33'h5000);
      repeat (3) @(negedge pclk);
      chk({31'h0, idle_irq_req, irq}, 33'h3);
      @(posedge pclk);
      rd(iit_pkg::IRQCTL_OFF, 33'h30);
      wr(iit_pkg::IRQCTL_OFF, 32'h10);
      wr(iit_pkg::CLEAR_OFF, 32'hf);
      rd(iit_pkg::IRQCTL_OFF, 33'h10);
      rd(iit_pkg::STATUS_OFF, 33'h0);
      chk({31'h0, idle_irq_req, irq}, 33'h0);
      wr(iit_pkg::ENABLE_OFF, 32'h0);
      wr(iit_pkg::CTRL_OFF, 32'h0);
      wr(iit_pkg::MODE_OFF, 32'h21);
      repeat (8) @(posedge pclk);
      chk({32'h0, instr_div_on}, 33'h0);
      gap(n);
      gap(n);
      chk(33'(n), 33'h4000);
      repeat (3) @(negedge pclk);
      chk({31'h0, idle_irq_req, irq}, 33'h0);
      @(posedge pclk);
      rd(iit_pkg::IRQCTL_OFF, 33'h30);
      chk({31'h0, wdog_tick_out, start_delay_done}, 33'h0);
      results();
   end
endmodule : iit_tb_top
`default_nettype wire
